// ### hw/asc_pkg.sv
// Constants and types of the serial control and status block.
//
// Functional notes
// - Standby hides receiver interrupts; the chosen wake event ends it.
// - Break set then cleared sends one break and a 1; held sends breaks.
// - A break requested before a pending preamble starts replaces it.
// - Received ninth bit loads with the data; 8-bit copies bit 7.
// - Ninth transmit bit is writable and loads with the transmit data.
// - Four error enables gate their error flags onto the error request.
// - Transmit empty sets on hand-off to the shifter; may interrupt.
// - Transmit empty clears by status one read, then data write.
// - Transmit done is set while empty and nothing is shifting.
// - Transmit done clears by itself once anything is queued.
// - Receive full sets when a character enters the data buffer.
// - Receive full clears by status one read, then data read.
// - Idle sets after a frame of ones; may interrupt; read-read clear.
// - Idle needs a received character after enable or after clearing.
// - Overrun keeps the old character, drops the new one, may interrupt.
// - Overrun clears only if it was seen at the status one read.
// - Noise flag sets on noisy samples; may interrupt; read-read clear.
// - Framing flag sets on a zero stop bit; may interrupt.
// - Parity flag sets on a parity mismatch; may interrupt.
// - A break sets break, framing and full flags; ninth bit clears.
// - Break flag clears by status two then data read; rearms on ones.
// - Wake select one wakes on an address mark, zero on idle line.
// - Length select one gives 9-bit characters, zero 8-bit.
package asc_pkg;
    localparam int TMR_W = 16;
    // Register offsets.
    localparam logic [2:0] OFF_CTL1 = 3'h0;
    localparam logic [2:0] OFF_CTL2 = 3'h1;
    localparam logic [2:0] OFF_CTL3 = 3'h2;
    localparam logic [2:0] OFF_STS1 = 3'h3;
    localparam logic [2:0] OFF_STS2 = 3'h4;
    localparam logic [2:0] OFF_DATA = 3'h5;
    // Field positions.
    localparam int C1_PODD   = 0;
    localparam int C1_PAR_ON = 1;
    localparam int C1_WAKE   = 3;
    localparam int C1_LEN9   = 4;
    localparam int C2_TXE_IE = 7;
    localparam int C2_DONE_IE = 6;
    localparam int C2_RXF_IE = 5;
    localparam int C2_IDL_IE = 4;
    localparam int C2_TX_EN  = 3;
    localparam int C2_RX_EN  = 2;
    localparam int C2_STBY   = 1;
    localparam int C2_BRK    = 0;
    localparam int C3_RX9    = 7;
    localparam int C3_TX9    = 6;
    localparam int S1_TXE    = 7;
    localparam int S1_DONE   = 6;
    localparam int S1_RXF    = 5;
    localparam int S1_IDL    = 4;
    localparam int S1_OVR    = 3;
    localparam int S1_NOIS   = 2;
    localparam int S1_FRM    = 1;
    localparam int S1_PAR    = 0;
    localparam int S2_BRK    = 1;
    // Masks, reset values and frame lengths.
    localparam logic [7:0] C1_WMASK  = 8'h1b;
    localparam logic [7:0] C3_WMASK  = 8'h4f;
    localparam logic [7:0] S1_RXMASK = 8'h3f;
    localparam logic [7:0] STS1_RST  = 8'hc0;
    localparam logic [3:0] FRAME8    = 4'ha;
    localparam logic [3:0] FRAME9    = 4'hb;
    // Engine states.
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00, TX_SEND = 2'b01, TX_BREAK = 2'b10
    } asc_tx_e;
    typedef enum logic [1:0] {
        RX_HUNT = 2'b00, RX_START = 2'b01, RX_BITS = 2'b10
    } asc_rx_e;
    // Register port request.
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } asc_req_s;
    // Whole state of the block.
    typedef struct packed {
        logic [7:0]       ctl1;
        logic [7:0]       ctl2;
        logic [7:0]       ctl3;
        logic [7:0]       s1;
        logic             brk_f;
        logic             brk_arm;
        logic [7:0]       snap1;
        logic             snap2;
        logic [7:0]       rx_data;
        logic [7:0]       tx_data;
        asc_tx_e          tx_st;
        logic [10:0]      tx_sh;
        logic [3:0]       tx_cnt;
        logic [TMR_W-1:0] tx_tmr;
        logic             pre_pend;
        logic             brk_pend;
        logic             tx_line;
        logic             rx_s1;
        logic             rx_s2;
        logic [2:0]       hist;
        asc_rx_e          rx_st;
        logic [9:0]       rx_sh;
        logic [3:0]       rx_cnt;
        logic [TMR_W-1:0] rx_tmr;
        logic             noise;
        logic [3:0]       ones;
        logic             idl_arm;
        logic [7:0]       rdata;
    } asc_state_s;
    localparam asc_state_s ST_RST = '{s1: STS1_RST, tx_st: TX_IDLE,
        tx_line: 1'b1, rx_s1: 1'b1, rx_s2: 1'b1, hist: 3'h7,
        rx_st: RX_HUNT, default: '0};
endpackage

// ### hw/asc_ctrl_status.sv
// Serial transceiver control, status flags and line engines.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module asc_ctrl_status #(
    parameter int BIT_CLKS = 16
) (
    // Clock, reset and clock enable.
    input  wire logic              clock_i,
    input  wire logic              srst_i,
    input  wire logic              ce_i,
    // Register port.
    input  wire asc_pkg::asc_req_s req_i,
    output logic [7:0]             rdata_o,
    // Serial pins.
    input  wire logic              rx_i,
    output logic                   tx_o,
    // Interrupt requests.
    output logic                   tx_irq_o,
    output logic                   rx_irq_o,
    output logic                   err_irq_o
);
    import asc_pkg::*;

    localparam logic [TMR_W-1:0] BIT_LAST = TMR_W'(BIT_CLKS - 1);
    localparam logic [TMR_W-1:0] BIT_MID  = TMR_W'(BIT_CLKS / 2);

    // Refuse bit periods the timers cannot hold.
    if (BIT_CLKS < 4 || BIT_CLKS > 65535)
    begin : g_bad
        $error("BIT_CLKS out of range");
    end

    // Frame length in bits for the selected character length.
    function automatic logic [3:0] frame_len(input logic len9);
        return len9 ? FRAME9 : FRAME8;
    endfunction

    // Parity bit over the data bits below the most significant one.
    function automatic logic par_bit(input logic [8:0] d,
                                     input logic len9,
                                     input logic odd);
        return (len9 ? ^d[7:0] : ^d[6:0]) ^ odd;
    endfunction

    asc_state_s  st_r;
    asc_state_s  st_nxt;
    logic        len9;
    logic        rd_s1;
    logic        rd_s2;
    logic        rd_dat;
    logic        wr_dat;
    logic [7:0]  clr;
    logic [8:0]  txd;
    logic        tx_go;
    logic        tx_tick;
    logic        rx_tick;
    logic        maj;
    logic        noisy;
    logic        rx_done;
    logic        rx_brk;
    logic        idle_ev;
    logic [9:0]  fr;
    logic [7:0]  rxd;
    logic        mark;
    logic        perr;

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // Register access, flag clearing and both line engines.
    always_comb
    begin
        st_nxt  = st_r;
        len9    = st_r.ctl1[C1_LEN9];
        rd_s1   = req_i.rd && req_i.addr == OFF_STS1;
        rd_s2   = req_i.rd && req_i.addr == OFF_STS2;
        rd_dat  = req_i.rd && req_i.addr == OFF_DATA;
        wr_dat  = req_i.wr && req_i.addr == OFF_DATA;
        rx_done = 1'b0;
        idle_ev = 1'b0;

        // Clear only what the last status read recorded.
        clr = rd_dat ? (st_r.snap1 & S1_RXMASK) : 8'h00;
        if (wr_dat)
        begin
            clr[S1_TXE] = st_r.snap1[S1_TXE];
        end
        st_nxt.s1 = st_r.s1 & ~clr;
        if (clr[S1_IDL])
        begin
            st_nxt.idl_arm = 1'b0;
        end
        if (rd_dat)
        begin
            st_nxt.snap1 = st_r.snap1 & ~S1_RXMASK;
            st_nxt.snap2 = 1'b0;
            if (st_r.snap2)
            begin
                st_nxt.brk_f = 1'b0;
            end
        end
        if (wr_dat)
        begin
            st_nxt.snap1[S1_TXE] = 1'b0;
            st_nxt.tx_data       = req_i.wdata;
        end
        // Status reads record which flags stand now.
        if (rd_s1)
        begin
            st_nxt.snap1 = st_r.s1;
        end
        if (rd_s2)
        begin
            st_nxt.snap2 = st_r.brk_f;
        end

        // Control register writes.
        if (req_i.wr && req_i.addr == OFF_CTL1)
        begin
            st_nxt.ctl1 = req_i.wdata & C1_WMASK;
        end
        if (req_i.wr && req_i.addr == OFF_CTL2)
        begin
            st_nxt.ctl2 = req_i.wdata;
            if (req_i.wdata[C2_TX_EN] && !st_r.ctl2[C2_TX_EN])
            begin
                st_nxt.pre_pend = 1'b1;
            end
            if (req_i.wdata[C2_RX_EN] && !st_r.ctl2[C2_RX_EN])
            begin
                st_nxt.idl_arm = 1'b0;
            end
            if (req_i.wdata[C2_BRK])
            begin
                st_nxt.brk_pend = 1'b1;
            end
        end
        if (req_i.wr && req_i.addr == OFF_CTL3)
        begin
            st_nxt.ctl3 = (req_i.wdata & C3_WMASK) | (st_r.ctl3 & ~C3_WMASK);
        end

        // Read data stand one cycle after the strobe.
        st_nxt.rdata = 8'h00;
        if (req_i.rd)
        begin
            case (req_i.addr)
                OFF_CTL1: st_nxt.rdata = st_r.ctl1;
                OFF_CTL2: st_nxt.rdata = st_r.ctl2;
                OFF_CTL3: st_nxt.rdata = st_r.ctl3;
                OFF_STS1: st_nxt.rdata = st_r.s1;
                OFF_STS2: st_nxt.rdata = {6'h00, st_r.brk_f, 1'b0};
                OFF_DATA: st_nxt.rdata = st_r.rx_data;
                default:  st_nxt.rdata = 8'h00;
            endcase
        end

        // Transmit character with optional parity in its top bit.
        txd = {st_r.ctl3[C3_TX9], st_r.tx_data};
        if (st_r.ctl1[C1_PAR_ON])
        begin
            if (len9)
            begin
                txd[8] = par_bit(txd, len9, st_r.ctl1[C1_PODD]);
            end
            else
            begin
                txd[7] = par_bit(txd, len9, st_r.ctl1[C1_PODD]);
            end
        end
        tx_go   = st_r.ctl2[C2_TX_EN];
        tx_tick = st_r.tx_tmr == BIT_LAST;
        st_nxt.tx_tmr = tx_tick ? '0 : st_r.tx_tmr + TMR_W'(1);

        // Transmit engine.
        unique case (st_r.tx_st)
            TX_IDLE:
            begin
                st_nxt.tx_tmr = '0;
                if (tx_go && (st_r.brk_pend || st_r.ctl2[C2_BRK]))
                begin
                    st_nxt.tx_st    = TX_BREAK;
                    st_nxt.tx_line  = 1'b0;
                    st_nxt.tx_cnt   = frame_len(len9);
                    st_nxt.brk_pend = 1'b0;
                    st_nxt.pre_pend = 1'b0;
                end
                else if (tx_go && st_r.pre_pend)
                begin
                    st_nxt.tx_st    = TX_SEND;
                    st_nxt.tx_sh    = '1;
                    st_nxt.tx_cnt   = frame_len(len9);
                    st_nxt.pre_pend = 1'b0;
                end
                else if (tx_go && !st_r.s1[S1_TXE])
                begin
                    st_nxt.tx_st      = TX_SEND;
                    st_nxt.tx_line    = 1'b0;
                    st_nxt.tx_sh      = len9 ? {2'b11, txd}
                                             : {3'b111, txd[7:0]};
                    st_nxt.tx_cnt     = frame_len(len9);
                    st_nxt.s1[S1_TXE] = 1'b1;
                end
            end
            TX_SEND:
            begin
                if (tx_tick && st_r.tx_cnt == 4'h1)
                begin
                    st_nxt.tx_st   = TX_IDLE;
                    st_nxt.tx_line = 1'b1;
                end
                else if (tx_tick)
                begin
                    st_nxt.tx_line = st_r.tx_sh[0];
                    st_nxt.tx_sh   = {1'b1, st_r.tx_sh[10:1]};
                    st_nxt.tx_cnt  = st_r.tx_cnt - 4'h1;
                end
            end
            TX_BREAK:
            begin
                if (tx_tick && st_r.tx_cnt == 4'h1)
                begin
                    if (st_r.ctl2[C2_BRK])
                    begin
                        st_nxt.tx_cnt   = frame_len(len9);
                        st_nxt.brk_pend = 1'b0;
                    end
                    else
                    begin
                        st_nxt.tx_st   = TX_SEND;
                        st_nxt.tx_line = 1'b1;
                        st_nxt.tx_sh   = '1;
                        st_nxt.tx_cnt  = 4'h1;
                    end
                end
                else if (tx_tick)
                begin
                    st_nxt.tx_cnt = st_r.tx_cnt - 4'h1;
                end
            end
            default:
            begin
                st_nxt.tx_st = TX_IDLE;
            end
        endcase

        // Done while empty and nothing shifts or waits to shift.
        st_nxt.s1[S1_DONE] = st_nxt.s1[S1_TXE] && st_nxt.tx_st == TX_IDLE
            && !st_nxt.pre_pend && !st_nxt.brk_pend
            && !st_nxt.ctl2[C2_BRK];

        // Receive pin synchroniser and three-sample majority vote.
        st_nxt.rx_s1 = rx_i;
        st_nxt.rx_s2 = st_r.rx_s1;
        st_nxt.hist  = {st_r.hist[1:0], st_r.rx_s2};
        maj   = (st_r.hist[0] & st_r.hist[1]) | (st_r.hist[0] & st_r.hist[2])
              | (st_r.hist[1] & st_r.hist[2]);
        noisy = !(&st_r.hist) && (|st_r.hist);
        rx_tick = st_r.rx_tmr == BIT_MID;
        st_nxt.rx_tmr = (st_r.rx_tmr == BIT_LAST) ? '0
                                                  : st_r.rx_tmr + TMR_W'(1);
        fr = {maj, st_r.rx_sh[9:1]};

        // Receive engine.
        unique case (st_r.rx_st)
            RX_HUNT:
            begin
                if (!st_r.ctl2[C2_RX_EN] || !st_r.rx_s2)
                begin
                    st_nxt.ones = 4'h0;
                end
                if (st_r.ctl2[C2_RX_EN] && !st_r.rx_s2 && st_r.hist[0])
                begin
                    st_nxt.rx_st  = RX_START;
                    st_nxt.rx_tmr = '0;
                    st_nxt.noise  = 1'b0;
                end
                else if (st_r.ctl2[C2_RX_EN] && st_r.rx_s2)
                begin
                    st_nxt.brk_arm = 1'b1;
                    if (st_r.rx_tmr == BIT_LAST
                        && st_r.ones != frame_len(len9))
                    begin
                        st_nxt.ones = st_r.ones + 4'h1;
                        idle_ev = st_nxt.ones == frame_len(len9);
                    end
                end
            end
            RX_START:
            begin
                if (rx_tick && maj)
                begin
                    st_nxt.rx_st = RX_HUNT;
                end
                else if (rx_tick)
                begin
                    st_nxt.rx_st  = RX_BITS;
                    st_nxt.rx_cnt = frame_len(len9) - 4'h1;
                    st_nxt.noise  = noisy;
                end
            end
            RX_BITS:
            begin
                if (rx_tick)
                begin
                    st_nxt.rx_sh  = fr;
                    st_nxt.noise  = st_r.noise | noisy;
                    st_nxt.rx_cnt = st_r.rx_cnt - 4'h1;
                    if (st_r.rx_cnt == 4'h1)
                    begin
                        rx_done      = 1'b1;
                        st_nxt.rx_st = RX_HUNT;
                        st_nxt.ones  = 4'h0;
                    end
                end
            end
            default:
            begin
                st_nxt.rx_st = RX_HUNT;
            end
        endcase

        // Decode the finished frame.
        rxd    = len9 ? fr[7:0] : fr[8:1];
        rx_brk = len9 ? (fr == 10'h000) : (fr[9:1] == 9'h000);
        mark   = len9 ? fr[8] : rxd[7];
        perr   = st_r.ctl1[C1_PAR_ON] && !rx_brk
              && mark != par_bit({fr[8], rxd}, len9, st_r.ctl1[C1_PODD]);
        if (rx_done && st_r.ctl2[C2_STBY] && st_r.ctl1[C1_WAKE] && mark)
        begin
            st_nxt.ctl2[C2_STBY] = 1'b0;
        end
        if (rx_done && !st_nxt.ctl2[C2_STBY])
        begin
            if (st_r.s1[S1_RXF] && !clr[S1_RXF])
            begin
                st_nxt.s1[S1_OVR] = 1'b1;
            end
            else
            begin
                st_nxt.rx_data     = rxd;
                st_nxt.ctl3[C3_RX9] = (rx_brk && len9) ? 1'b0 : fr[8];
                st_nxt.s1[S1_RXF]  = 1'b1;
                st_nxt.idl_arm     = 1'b1;
                st_nxt.s1[S1_FRM]  = st_nxt.s1[S1_FRM] | !fr[9];
                st_nxt.s1[S1_PAR]  = st_nxt.s1[S1_PAR] | perr;
                st_nxt.s1[S1_NOIS] = st_nxt.s1[S1_NOIS] | st_nxt.noise;
                if (rx_brk && st_r.brk_arm)
                begin
                    st_nxt.brk_f   = 1'b1;
                    st_nxt.brk_arm = 1'b0;
                end
            end
        end

        // An idle line wakes the receiver or raises the idle flag.
        if (idle_ev && st_r.ctl2[C2_STBY] && !st_r.ctl1[C1_WAKE])
        begin
            st_nxt.ctl2[C2_STBY] = 1'b0;
        end
        else if (idle_ev && !st_r.ctl2[C2_STBY] && st_r.idl_arm)
        begin
            st_nxt.s1[S1_IDL] = 1'b1;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // Reset leaves the received data and ninth bit untouched.
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            st_r               <= ST_RST;
            st_r.ctl3[C3_RX9]  <= st_r.ctl3[C3_RX9];
            st_r.rx_data       <= st_r.rx_data;
        end
        else if (ce_i)
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs and interrupt requests.
    assign rdata_o   = st_r.rdata;
    assign tx_o      = st_r.tx_line;
    assign tx_irq_o  = (st_r.s1[S1_TXE] && st_r.ctl2[C2_TXE_IE])
                    || (st_r.s1[S1_DONE] && st_r.ctl2[C2_DONE_IE]);
    assign rx_irq_o  = !st_r.ctl2[C2_STBY]
                    && ((st_r.s1[S1_RXF] && st_r.ctl2[C2_RXF_IE])
                    || (st_r.s1[S1_IDL] && st_r.ctl2[C2_IDL_IE]));
    assign err_irq_o = |(st_r.s1[S1_OVR:S1_PAR]
                       & st_r.ctl3[S1_OVR:S1_PAR]);

    // ****************************************************************
    // Checks
    // ****************************************************************

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    property p_stby_quiet;
        st_r.ctl2[C2_STBY] |-> !rx_irq_o;
    endproperty
    a_stby_quiet: assert property (p_stby_quiet)
        else $error("receiver request during standby");

    property p_err_gate;
        st_r.ctl3[3:0] == 4'h0 |-> !err_irq_o;
    endproperty
    a_err_gate: assert property (p_err_gate)
        else $error("error request with all enables clear");

    property p_load;
        ce_i && st_r.tx_st == TX_IDLE && tx_go && !st_r.s1[S1_TXE]
        && !st_r.brk_pend && !st_r.ctl2[C2_BRK] && !st_r.pre_pend
        |=> st_r.s1[S1_TXE] && st_r.tx_st == TX_SEND && !tx_o;
    endproperty
    a_load: assert property (p_load)
        else $error("buffer hand-off did not start a frame");

    property p_done;
        st_r.s1[S1_DONE] |-> st_r.s1[S1_TXE] && st_r.tx_st == TX_IDLE;
    endproperty
    a_done: assert property (p_done)
        else $error("done flag while shifting");

    property p_rxf_clr;
        ce_i && rd_s1 && st_r.s1[S1_RXF] ##1 ce_i && rd_dat && !rx_done
        |=> !st_r.s1[S1_RXF];
    endproperty
    a_rxf_clr: assert property (p_rxf_clr)
        else $error("receive full not cleared");

    property p_ovr_keep;
        ce_i && rd_dat && !st_r.snap1[S1_OVR] && st_r.s1[S1_OVR]
        |=> st_r.s1[S1_OVR];
    endproperty
    a_ovr_keep: assert property (p_ovr_keep)
        else $error("late overrun was cleared");

    property p_ovr_set;
        ce_i && rx_done && st_r.s1[S1_RXF] && !rd_dat && !st_r.ctl2[C2_STBY]
        |=> st_r.s1[S1_OVR] && st_r.rx_data == $past(st_r.rx_data);
    endproperty
    a_ovr_set: assert property (p_ovr_set)
        else $error("overrun lost or data replaced");

    property p_idle_arm;
        $rose(st_r.s1[S1_IDL]) |-> $past(st_r.idl_arm);
    endproperty
    a_idle_arm: assert property (p_idle_arm)
        else $error("idle set without a prior character");

    property p_brk_rx;
        ce_i && rx_done && rx_brk && st_r.brk_arm && !st_r.s1[S1_RXF]
        && !st_r.ctl2[C2_STBY]
        |=> st_r.brk_f && st_r.s1[S1_FRM] && st_r.s1[S1_RXF];
    endproperty
    a_brk_rx: assert property (p_brk_rx)
        else $error("break did not set its flags");

    c_break_sent: cover property (st_r.tx_st == TX_BREAK ##1
                                  st_r.tx_st == TX_SEND);
    c_overrun: cover property ($rose(st_r.s1[S1_OVR]));
    c_idle: cover property ($rose(st_r.s1[S1_IDL]));
endmodule
`default_nettype wire

// ### verif/asc_far_node.sv
// Far serial node model: sends frames and captures frames.
`timescale 1ns/100ps
`default_nettype none
module asc_far_node #(
    parameter int BIT_CLKS = 4
) (
    input  wire logic clock_i,
    input  wire logic tx_i,
    output logic      rx_o
);
    // The line idles high, as a pulled-up receive pin would.
    initial rx_o = 1'b1;
    // Sends start, eight data bits LSB first and the given stop level.
    task automatic send(input logic [7:0] d, input logic s);
        logic [9:0] fr;
        fr = {s, d, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rx_o <= fr[i];
            repeat (BIT_CLKS) @(posedge clock_i);
        end
        rx_o <= 1'b1;
        @(posedge clock_i);
    endtask
    // Captures data and stop level at the middle of each bit.
    task automatic get(output logic [8:0] q);
        @(negedge tx_i);
        repeat (BIT_CLKS / 2) @(posedge clock_i);
        for (int i = 0; i < 9; i++)
        begin
            repeat (BIT_CLKS) @(posedge clock_i);
            q[i] = tx_i;
        end
    endtask
endmodule
`default_nettype wire

// ### verif/asc_ctrl_status_bench.sv
// Self-checking bench for the serial control and status block.
`timescale 1ns/100ps
`default_nettype none
module asc_ctrl_status_bench;
    import asc_pkg::*;
    localparam int BC = 4;
    logic       clock_i, srst_i, tx_o, rx_w, ce;
    logic       tx_irq_o, rx_irq_o, err_irq_o;
    logic [7:0] rdata_o, q;
    logic [8:0] f;
    asc_req_s   req;
    int         failures = 0;
    int         compares = 0;
    logic [10:0] rows [6] = '{11'h3c0, 11'h400, 11'h000, 11'h100,
                              11'h600, 11'h700};
    asc_ctrl_status #(.BIT_CLKS(BC)) i_dut (.clock_i(clock_i),
        .srst_i(srst_i), .ce_i(ce), .req_i(req), .rdata_o(rdata_o),
        .rx_i(rx_w), .tx_o(tx_o), .tx_irq_o(tx_irq_o),
        .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o));
    asc_far_node #(.BIT_CLKS(BC)) i_far (.clock_i(clock_i),
        .tx_i(tx_o), .rx_o(rx_w));
    // Clock of 50 ns period.
    initial
    begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    // Counts every comparison and reports a difference.
    task automatic chk(input logic [8:0] s, input logic [8:0] e);
        compares++;
        if (s !== e)
        begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // One-cycle register write; the strobe drops a cycle later.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clock_i);
        req.wr <= 1'b0;
        @(posedge clock_i);
    endtask
    // One-cycle read; data is taken in the cycle after the strobe.
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clock_i);
        req.rd <= 1'b0;
        #1 v = rdata_o;
        @(posedge clock_i);
    endtask
    task automatic rc(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(9'(v), 9'(e));
    endtask
    // Status one read and data read on back-to-back strobes.
    task automatic rr(input logic [7:0] es, input logic [7:0] ed);
        logic [7:0] v;
        req.addr <= OFF_STS1;
        req.rd <= 1'b1;
        @(posedge clock_i);
        req.addr <= OFF_DATA;
        #1 v = rdata_o;
        chk(9'(v), 9'(es));
        @(posedge clock_i);
        req.rd <= 1'b0;
        #1 v = rdata_o;
        chk(9'(v), 9'(ed));
        @(posedge clock_i);
    endtask
    // Lets the idle flag come up, then clears it.
    task automatic flush();
        repeat (60) @(posedge clock_i);
        rd(OFF_STS1, q);
        rd(OFF_DATA, q);
    endtask
    task automatic summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog cuts a hang short.
    initial
    begin
        repeat (5000) @(posedge clock_i);
        failures++;
        summarize();
    end
    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial
    begin
        srst_i = 1'b1;
        ce = 1'b1;
        req = '0;
        repeat (16) @(posedge clock_i);
        srst_i <= 1'b0;
        @(posedge clock_i);
        for (int i = 0; i < 6; i++)
            rc(rows[i][10:8], rows[i][7:0]);
        $display("reset values done");
        wr(OFF_CTL2, 8'h2c);
        i_far.send(8'ha5, 1'b1);
        repeat (4) @(posedge clock_i);
        chk(9'(rx_irq_o), 9'h1);
        rr(8'he0, 8'ha5);
        rc(OFF_CTL3, 8'h80);
        repeat (60) @(posedge clock_i);
        rc(OFF_STS1, 8'hd0);
        rc(OFF_DATA, 8'ha5);
        repeat (60) @(posedge clock_i);
        rc(OFF_STS1, 8'hc0);
        $display("receive and idle done");
        wr(OFF_CTL3, 8'h08);
        i_far.send(8'h11, 1'b1);
        repeat (4) @(posedge clock_i);
        rc(OFF_STS1, 8'he0);
        i_far.send(8'h22, 1'b1);
        repeat (4) @(posedge clock_i);
        chk(9'(err_irq_o), 9'h1);
        rc(OFF_DATA, 8'h11);
        rr(8'hc8, 8'h11);
        rc(OFF_STS1, 8'hc0);
        flush();
        $display("overrun done");
        i_far.send(8'h00, 1'b0);
        repeat (4) @(posedge clock_i);
        rc(OFF_STS1, 8'he2);
        rc(OFF_STS2, 8'h02);
        rc(OFF_DATA, 8'h00);
        rc(OFF_STS2, 8'h00);
        flush();
        $display("break receive done");
        wr(OFF_CTL1, 8'h08);
        wr(OFF_CTL2, 8'h2e);
        i_far.send(8'h11, 1'b1);
        repeat (4) @(posedge clock_i);
        rc(OFF_STS1, 8'hc0);
        i_far.send(8'h91, 1'b1);
        repeat (4) @(posedge clock_i);
        chk(9'(rx_irq_o), 9'h1);
        rc(OFF_CTL2, 8'h2c);
        rr(8'he0, 8'h91);
        wr(OFF_CTL1, 8'h02);
        i_far.send(8'h01, 1'b1);
        repeat (4) @(posedge clock_i);
        rc(OFF_STS1, 8'he1);
        wr(OFF_CTL1, 8'h00);
        flush();
        $display("standby and parity done");
        rd(OFF_STS1, q);
        fork
            i_far.get(f);
            begin
                wr(OFF_DATA, 8'h3c);
                repeat (8) @(posedge clock_i);
                rc(OFF_STS1, 8'h80);
            end
        join
        chk(f, 9'h13c);
        repeat (8) @(posedge clock_i);
        rc(OFF_STS1, 8'hc0);
        fork
            i_far.get(f);
            begin
                wr(OFF_CTL2, 8'h2d);
                wr(OFF_CTL2, 8'h2c);
            end
        join
        chk(f, 9'h000);
        repeat (BC) @(posedge clock_i);
        chk(9'(tx_o), 9'h1);
        $display("transmit done");
        chk(9'(tx_irq_o), 9'h0);
        wr(OFF_CTL2, 8'hac);
        chk(9'(tx_irq_o), 9'h1);
        ce <= 1'b0;
        wr(OFF_CTL1, 8'h1b);
        rd(OFF_CTL1, q);
        ce <= 1'b1;
        chk(9'(q), 9'h000);
        rc(OFF_CTL1, 8'h00);
        $display("interrupt and freeze done");
        summarize();
    end
endmodule
`default_nettype wire
